//--- design/sstone_pkg.sv
/*
  Package for the switch-tuned square wave tone block: register offsets,
  field positions, reset values, timing constants and bus carrier types.
  Assumes a single 200 MHz clock and an Avalon-MM register slave.
*/
package sstone_pkg;

  localparam int          ADDR_W          = 16;
  localparam int          DATA_W          = 32;
  localparam logic [15:0] PORT_DATA_ADDR  = 16'h1700;
  localparam logic [15:0] PORT_DIR_ADDR   = 16'h1701;
  localparam logic [15:0] CTRL_ADDR       = 16'h1704;
  localparam logic [15:0] STAT_ADDR       = 16'h1708;

  localparam logic [7:0]  DIR_RESET       = 8'h00;
  localparam logic [7:0]  DIR_INIT        = 8'h01;
  localparam logic [7:0]  DATA_RESET      = 8'h00;
  localparam logic [7:0]  ALL_ONES        = 8'hFF;
  localparam int          TONE_BIT        = 0;
  localparam int          CNT_W           = 7;

  // loop timing: cycles of the 1 MHz machine clock
  localparam int          MACH_HZ         = 1000000;
  localparam int          SYS_HZ          = 200000000;
  localparam int          HALF_BASE_CYC   = 23;
  localparam int          HALF_STEP_CYC   = 5;
  localparam int          TICK_DIV        = SYS_HZ / MACH_HZ;

  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic              read;
    logic              write;
    logic [DATA_W-1:0] writedata;
  } sstone_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] readdata;
    logic              waitrequest;
  } sstone_rsp_t;

  typedef enum logic [1:0] {
    ST_RESET = 2'b00,
    ST_INIT  = 2'b01,
    ST_LOOP  = 2'b11
  } sstone_state_t;

endpackage

//--- design/sstone_top.sv
/*
  Switch-tuned square wave tone generator: an 8-bit port with data and
  direction registers, a tone on bit 0, and a delay count taken from the
  seven switch inputs. Assumes inputs synchronous to clk and a single
  Avalon-MM master; one machine cycle is one 1 MHz tick derived from clk.
*/
// Local design decision: the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - direction register at 0x1701, bit 1 means output; init writes 0x01.
// - data register at 0x1700 reads live inputs; tone toggle spares pins 1-7.
// - endless loop: toggle tone, sample switches, derive count, wait, repeat.
// - count is complemented port byte shifted right one bit.
// - count spans 0 to 127, from the seven switch inputs only.
// - loop timing counted in 1 MHz machine cycles of one microsecond.
// - full period 46 plus 10 times count; half period 23 plus 5 count.
// - all switches open gives highest tone; all closed gives lowest.
// - pin 1 switch is count lsb, pin 7 switch is count msb.
module sstone_top #(
  parameter int TICK_DIV = sstone_pkg::TICK_DIV
) (
  input  wire logic                 clk,       // 200 MHz
  input  wire logic                 srst,      // sync reset, active high
  input  wire sstone_pkg::sstone_req_t bus_req, // avalon request
  output var  sstone_pkg::sstone_rsp_t bus_rsp, // avalon answer
  input  wire logic [7:0]           port_in,   // pin levels
  output logic      [7:0]           port_out,  // pin drive values
  output logic      [7:0]           port_oe,   // pin enables
  output logic                      tone_output_pin // tone, bit 0 level
);

  function automatic logic [6:0] derive_count(input logic [7:0] pins);
    logic [7:0] inv;
    inv = pins ^ sstone_pkg::ALL_ONES;
    derive_count = inv[7:1];
  endfunction

  function automatic logic [15:0] half_cycles(input logic [6:0] cnt);
    half_cycles = 16'(sstone_pkg::HALF_BASE_CYC)
                + 16'(sstone_pkg::HALF_STEP_CYC) * 16'(cnt);
  endfunction

  sstone_pkg::sstone_state_t state_reg, state_next;
  logic [7:0]  dir_reg, dir_next;
  logic [7:0]  data_reg, data_next;
  logic [7:0]  tick_reg, tick_next;
  logic [15:0] wait_reg, wait_next;
  logic [6:0]  count_reg, count_next;
  logic        run_reg, run_next;
  logic [31:0] rdata_reg, rdata_next;
  logic        ack_reg, ack_next;
  logic        tick;

  assign tick = (tick_reg == 8'(TICK_DIV - 1));

  wire logic        access  = (bus_req.read | bus_req.write) & ~ack_reg;
  wire logic [15:0] addr    = bus_req.address;
  wire logic [7:0]  live_rd = (port_in & ~dir_reg) | (data_reg & dir_reg);

  always_comb begin
    state_next = state_reg;
    dir_next   = dir_reg;
    data_next  = data_reg;
    tick_next  = tick ? 8'h00 : tick_reg + 8'h01;
    wait_next  = wait_reg;
    count_next = count_reg;
    run_next   = run_reg;
    rdata_next = rdata_reg;
    ack_next   = access;
    case (state_reg)
      sstone_pkg::ST_RESET: begin
        if (run_reg) begin
          state_next = sstone_pkg::ST_INIT;
        end
      end
      sstone_pkg::ST_INIT: begin
        dir_next   = sstone_pkg::DIR_INIT;
        wait_next  = 16'h0001;
        state_next = sstone_pkg::ST_LOOP;
      end
      sstone_pkg::ST_LOOP: begin
        if (!run_reg) begin
          state_next = sstone_pkg::ST_RESET;
        end else if (tick) begin
          if (wait_reg == 16'h0001) begin
            // toggle only bit 0; upper bits untouched
            data_next[sstone_pkg::TONE_BIT] = ~data_reg[sstone_pkg::TONE_BIT];
            count_next = derive_count(port_in);
            wait_next  = half_cycles(derive_count(port_in));
          end else begin
            wait_next = wait_reg - 16'h0001;
          end
        end
      end
      default: state_next = sstone_pkg::ST_RESET;
    endcase
    if (access && bus_req.write) begin
      case (addr)
        sstone_pkg::PORT_DATA_ADDR: data_next = bus_req.writedata[7:0];
        sstone_pkg::PORT_DIR_ADDR:  dir_next  = bus_req.writedata[7:0];
        sstone_pkg::CTRL_ADDR:      run_next  = bus_req.writedata[0];
        default: ;
      endcase
    end
    if (access && bus_req.read) begin
      case (addr)
        sstone_pkg::PORT_DATA_ADDR: rdata_next = {24'h000000, live_rd};
        sstone_pkg::PORT_DIR_ADDR:  rdata_next = {24'h000000, dir_reg};
        sstone_pkg::CTRL_ADDR:      rdata_next = {31'h00000000, run_reg};
        sstone_pkg::STAT_ADDR:      rdata_next = {23'h000000, count_reg, state_reg};
        default:                    rdata_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state_reg <= sstone_pkg::ST_RESET;
      dir_reg   <= sstone_pkg::DIR_RESET;
      data_reg  <= sstone_pkg::DATA_RESET;
      tick_reg  <= 8'h00;
      wait_reg  <= 16'h0000;
      count_reg <= 7'h00;
      run_reg   <= 1'b1;
      rdata_reg <= 32'h00000000;
      ack_reg   <= 1'b0;
    end else begin
      state_reg <= state_next;
      dir_reg   <= dir_next;
      data_reg  <= data_next;
      tick_reg  <= tick_next;
      wait_reg  <= wait_next;
      count_reg <= count_next;
      run_reg   <= run_next;
      rdata_reg <= rdata_next;
      ack_reg   <= ack_next;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      port_out        <= 8'h00;
      port_oe         <= 8'h00;
      tone_output_pin <= 1'b0;
      bus_rsp         <= '{readdata: 32'h00000000, waitrequest: 1'b1};
    end else begin
      port_out        <= data_next;
      port_oe         <= dir_next;
      tone_output_pin <= data_next[sstone_pkg::TONE_BIT] & dir_next[sstone_pkg::TONE_BIT];
      bus_rsp         <= '{readdata: rdata_next, waitrequest: ~access};
    end
  end

  // assertions
  property toggle_spacing_p;
    @(posedge clk) disable iff (srst)
      ($changed(data_reg[0]) && state_reg == sstone_pkg::ST_LOOP && run_reg
       && $past(state_reg) == sstone_pkg::ST_LOOP
       && !($past(access) && $past(bus_req.write)))
      |-> (wait_reg == half_cycles(count_reg));
  endproperty
  toggle_spacing_a: assert property (toggle_spacing_p)
    else $error("half period not loaded from count");

  init_dir_a: assert property (@(posedge clk) disable iff (srst)
    state_reg == sstone_pkg::ST_INIT |=> dir_reg == sstone_pkg::DIR_INIT)
    else $error("direction not set by init");

  upper_keep_a: assert property (@(posedge clk) disable iff (srst)
    (state_reg == sstone_pkg::ST_LOOP && !(access && bus_req.write))
      |=> data_reg[7:1] == $past(data_reg[7:1]))
    else $error("toggle disturbed upper pins");

  count_form_a: assert property (@(posedge clk) disable iff (srst)
    (state_reg == sstone_pkg::ST_LOOP && run_reg && tick && wait_reg == 16'h0001)
      |=> count_reg == 7'(~$past(port_in) >> 1))
    else $error("count not complemented and shifted");

  reset_clear_a: assert property (@(posedge clk)
    srst |=> dir_reg == 8'h00 && data_reg == 8'h00 && !tone_output_pin)
    else $error("reset left state");

  tick_rate_a: assert property (@(posedge clk) disable iff (srst)
    tick |=> !tick [*2])
    else $error("tick too frequent");

  sequence loop_wait_s;
    state_reg == sstone_pkg::ST_LOOP && run_reg && tick && wait_reg > 16'h0001
      && !(access && bus_req.write);
  endsequence
  loop_hold_a: assert property (@(posedge clk) disable iff (srst)
    loop_wait_s |=> $stable(data_reg[0]) && wait_reg == $past(wait_reg) - 16'h0001)
    else $error("tone moved during wait");

  count_range_a: assert property (@(posedge clk) disable iff (srst)
    wait_reg <= half_cycles(7'h7F))
    else $error("wait beyond max count");

  bus_ack_a: assert property (@(posedge clk) disable iff (srst)
    (bus_req.read && bus_rsp.waitrequest) |-> ##[0:2] !bus_rsp.waitrequest)
    else $error("bus not answered");

  write_ack_a: assert property (@(posedge clk) disable iff (srst)
    (bus_req.write && bus_rsp.waitrequest) |-> ##[0:2] !bus_rsp.waitrequest)
    else $error("write not answered");

  // answer lasts one cycle; a strobe still held in that cycle is not taken twice
  ack_single_a: assert property (@(posedge clk) disable iff (srst)
    !bus_rsp.waitrequest |=> bus_rsp.waitrequest)
    else $error("waitrequest low too long");

  tone_gate_a: assert property (@(posedge clk) disable iff (srst)
    tone_output_pin == (data_reg[sstone_pkg::TONE_BIT] & dir_reg[sstone_pkg::TONE_BIT]))
    else $error("tone pin not gated by direction");

  port_mirror_a: assert property (@(posedge clk) disable iff (srst)
    port_oe == dir_reg && port_out == data_reg)
    else $error("port pins differ from registers");

endmodule

`default_nettype wire

//--- tb/sstone_partner.sv
/*
  Far side of the tone block: seven grounded switches on pins 1-7.
  Assumes every pin has a pull-up and the block drives pins where port_oe is set.
*/
`timescale 1ns/10ps
`default_nettype none
module sstone_partner (
  input  wire logic [7:0] port_out, // block drive values
  input  wire logic [7:0] port_oe,  // block enables
  input  wire logic [7:0] closed,   // switch closed, bit 0 unused
  output logic      [7:0] port_in   // pin levels
);
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (port_oe[i])
        port_in[i] = port_out[i];
      else if (i > 0 && closed[i])
        port_in[i] = 1'b0;
      else
        port_in[i] = 1'b1;
    end
  end
endmodule
`default_nettype wire

//--- tb/sstone_top_tb.sv
/*
  Self-checking bench for the tone block: toggle spacing, port reads, reset.
  Assumes a shortened tick divider so each machine cycle is TD clocks.
*/
`timescale 1ns/10ps
`default_nettype none
module sstone_top_tb;
  localparam int TD = 3;
  typedef struct {logic [7:0] sw; int half;} sstone_row_t;
  logic                    clk;
  logic                    srst;
  sstone_pkg::sstone_req_t req;
  sstone_pkg::sstone_rsp_t rsp;
  logic [7:0]              pin;
  logic [7:0]              pout;
  logic [7:0]              poe;
  logic [7:0]              sw;
  logic                    tone;
  logic [31:0]             rd;
  logic                    t0;
  int                      errors;
  int                      cmp_count;
  int                      n;
  sstone_row_t rows [5] = '{'{8'h00, 23}, '{8'h02, 28}, '{8'h80, 343},
                            '{8'hFE, 658}, '{8'h54, 233}};

  sstone_top #(.TICK_DIV(TD)) uut (.clk(clk), .srst(srst), .bus_req(req), .bus_rsp(rsp),
    .port_in(pin), .port_out(pout), .port_oe(poe), .tone_output_pin(tone));
  sstone_partner far (.port_out(pout), .port_oe(poe), .closed(sw), .port_in(pin));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task results;
    $display("errors=%0d cmp_count=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task cmp(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // gap edge first, so a strobe is never dropped and raised in one step
  task bus(input logic wr, input logic [15:0] a, input logic [31:0] wd);
    int k;
    @(posedge clk);
    req <= '{address: a, read: !wr, write: wr, writedata: wd};
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (rsp.waitrequest === 1'b0)
        break;
    end
    if (k == 50) begin
      errors++;
      results;
    end
    rd = rsp.readdata;
    req <= '0;
  endtask

  task wait_edge(output int c);
    logic t;
    t = tone;
    for (c = 0; c < 5000; c++) begin
      @(posedge clk);
      if (tone !== t)
        break;
    end
    if (c == 5000) begin
      errors++;
      results;
    end
    c = c + 1;
  endtask

  initial begin
    errors = 0;
    cmp_count = 0;
    srst = 1'b1;
    req = '0;
    sw = 8'h00;
    repeat (6) @(posedge clk);
    cmp({24'h0, poe}, 32'h0);
    cmp({31'h0, tone}, 32'h0);
    srst <= 1'b0;
    // count is latched at a toggle, so skip one interval after a change
    for (int i = 0; i < 5; i++) begin
      wait_edge(n);
      sw <= rows[i].sw;
      wait_edge(n);
      wait_edge(n);
      cmp(n, rows[i].half * TD);
    end
    wait_edge(n);
    sw <= 8'h00;
    wait_edge(n);
    cmp(n, 233 * TD);
    cmp({24'h0, poe}, 32'h1);
    bus(1'b0, sstone_pkg::PORT_DIR_ADDR, 32'h0);
    cmp(rd, 32'h1);
    sw <= 8'h54;
    bus(1'b1, sstone_pkg::PORT_DATA_ADDR, 32'hFE);
    bus(1'b0, sstone_pkg::PORT_DATA_ADDR, 32'h0);
    cmp(rd & 32'hFE, 32'hAA);
    bus(1'b0, 16'h1710, 32'h0);
    cmp(rd, 32'h0);
    wait_edge(n);
    wait_edge(n);
    cmp(n, 233 * TD);
    cmp({24'h0, pout & 8'hFE}, 32'hFE);
    bus(1'b0, sstone_pkg::STAT_ADDR, 32'h0);
    cmp(rd, 32'hAB);
    // stopped loop must leave the tone still
    bus(1'b1, sstone_pkg::CTRL_ADDR, 32'h0);
    t0 = tone;
    n = 0;
    repeat (2000) begin
      @(posedge clk);
      if (tone !== t0)
        n++;
    end
    cmp(n, 0);
    bus(1'b1, sstone_pkg::CTRL_ADDR, 32'h1);
    bus(1'b0, sstone_pkg::CTRL_ADDR, 32'h0);
    cmp(rd, 32'h1);
    wait_edge(n);
    wait_edge(n);
    cmp(n, 233 * TD);
    // reset in mid-run
    srst <= 1'b1;
    repeat (3) @(posedge clk);
    cmp({24'h0, pout}, 32'h0);
    cmp({24'h0, poe}, 32'h0);
    cmp({31'h0, tone}, 32'h0);
    srst <= 1'b0;
    repeat (3) @(posedge clk);
    cmp({24'h0, poe}, 32'h1);
    wait_edge(n);
    wait_edge(n);
    cmp(n, 233 * TD);
    results;
  end
endmodule
`default_nettype wire
